/* File: epp_pkg.sv */
// Package of constants for the EPROM programmer controller.
package epp_pkg;
  // Operation codes taken at the user port.
  localparam logic [2:0] OP_PROG_CODE = 3'h0;
  localparam logic [2:0] OP_PROG_KEY = 3'h1;
  localparam logic [2:0] OP_LOCK_ONE = 3'h2;
  localparam logic [2:0] OP_LOCK_TWO = 3'h3;
  localparam logic [2:0] OP_LOCK_THREE = 3'h4;
  localparam logic [2:0] OP_VERIFY = 3'h5;
  localparam logic [2:0] OP_SIGNATURE = 3'h6;
  // Mode pin levels {a, enable, b, c, d} for each operation.
  localparam logic [4:0] MODE_PROG_CODE = 5'h0f;
  localparam logic [4:0] MODE_PROG_KEY = 5'h0d;
  localparam logic [4:0] MODE_LOCK_ONE = 5'h1f;
  localparam logic [4:0] MODE_LOCK_TWO = 5'h1c;
  localparam logic [4:0] MODE_LOCK_THREE = 5'h16;
  localparam logic [4:0] MODE_VERIFY = 5'h03;
  localparam logic [4:0] MODE_SIGNATURE = 5'h00;
  // Strobe pulses per location.
  localparam logic [4:0] PULSES_CODE = 5'h05;
  localparam logic [4:0] PULSES_OTHER = 5'h19;
  // Highest valid encryption array address.
  localparam logic [14:0] KEY_ADDR_MAX = 15'h003f;
  // Timing, in the unit given, and in 10 ns clock cycles.
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_CLK_DIV = 10;
  localparam int TCLCL_NS = 2 * OSC_CLK_DIV * CLK_PERIOD_NS;
  localparam int SETUP_TCLCL = 48;
  localparam int SETUP_CYC = (SETUP_TCLCL * TCLCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VPP_SETUP_US = 10;
  localparam int VPP_SETUP_CYC = (VPP_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MIN_US = 90;
  localparam int PULSE_MAX_US = 110;
  localparam int PULSE_CYC = ((PULSE_MIN_US + PULSE_MAX_US) / 2) * 1000 / CLK_PERIOD_NS;
  localparam int GAP_US = 10;
  localparam int GAP_CYC = (GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 14;
endpackage

/* File: epp_host.sv */
// Controller that drives the EPROM programming and verify pins of the device.
// How it works
// - The oscillator output toggles every 10 system clocks, giving 5 MHz, inside 4 to 6 MHz.
// - The 15-bit address splits into eight low lines, six middle lines and one top line.
// - The data lines carry the code byte out when programming and are read back on verify.
// - Code programming holds reset high, store enable low, mode a low and the rest high.
// - Encryption array programming uses the code levels with mode c low, addresses 0 to 3f only.
// - Lock bits use mode a high with the three fixed patterns of the other pins.
// - Verify and signature reads release the data lines with the strobe and voltage high.
// - Address, data and mode are set up first, then the voltage, then the strobe pulses.
// - Program voltage is raised only around the pulses and dropped back to logic high after.
// - Five pulses are given per code byte and twenty-five per array byte or lock bit.
// - Filling unused code with varied non-ff values is left to the user who feeds bytes.
`timescale 1ns/1ns
module epp_host (
  // Clock, reset and freeze.
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // User command port.
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_op_i,
  input wire logic [14:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic error_o,
  output logic [7:0] rd_data_o,
  // Device pins.
  output logic osc_o,
  output logic reset_pin_o,
  output logic program_store_enable_o,
  output logic latch_strobe_program_pulse_o,
  output logic external_access_program_voltage_o,
  output logic mode_pin_a_o,
  output logic enable_pin_o,
  output logic mode_pin_b_o,
  output logic mode_pin_c_o,
  output logic mode_pin_d_o,
  output logic [7:0] low_address_lines_o,
  output logic [5:0] mid_address_lines_o,
  output logic top_address_line_o,
  input wire logic [7:0] data_port_lines_i,
  output logic [7:0] data_port_lines_o,
  output logic data_port_lines_oe_o
);
  typedef enum logic [2:0] {EPP_IDLE, EPP_SETUP, EPP_VPP_ON, EPP_PULSE, EPP_GAP,
    EPP_VPP_OFF, EPP_READ} epp_state_t;

  localparam logic [13:0] SETUP_N = 14'(epp_pkg::SETUP_CYC - 1);
  localparam logic [13:0] VPP_N = 14'(epp_pkg::VPP_SETUP_CYC - 1);
  localparam logic [13:0] PULSE_N = 14'(epp_pkg::PULSE_CYC - 1);
  localparam logic [13:0] GAP_N = 14'(epp_pkg::GAP_CYC - 1);
  localparam logic [3:0] OSC_N = 4'(epp_pkg::OSC_CLK_DIV - 1);

  function automatic logic [4:0] mode_of(input logic [2:0] op);
    case (op)
      epp_pkg::OP_PROG_CODE: mode_of = epp_pkg::MODE_PROG_CODE;
      epp_pkg::OP_PROG_KEY: mode_of = epp_pkg::MODE_PROG_KEY;
      epp_pkg::OP_LOCK_ONE: mode_of = epp_pkg::MODE_LOCK_ONE;
      epp_pkg::OP_LOCK_TWO: mode_of = epp_pkg::MODE_LOCK_TWO;
      epp_pkg::OP_LOCK_THREE: mode_of = epp_pkg::MODE_LOCK_THREE;
      epp_pkg::OP_SIGNATURE: mode_of = epp_pkg::MODE_SIGNATURE;
      default: mode_of = epp_pkg::MODE_VERIFY;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  epp_state_t state_q, state_d;
  logic [13:0] timer_q, timer_d;
  logic [4:0] pulses_q, pulses_d;
  logic [3:0] osc_cnt_q;
  logic osc_q;
  logic [2:0] op_q;
  logic [14:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] sync1_q, sync2_q;
  logic [4:0] mode_q;
  logic vpp_q, strobe_n_q, oe_q, ready_q, done_q, err_q;
  logic [7:0] rdata_q;

  wire logic timer_done = (timer_q == 14'h0000);
  wire logic is_read = (cmd_op_i == epp_pkg::OP_VERIFY) || (cmd_op_i == epp_pkg::OP_SIGNATURE);
  wire logic bad_op = (cmd_op_i > epp_pkg::OP_SIGNATURE);
  wire logic bad_key = (cmd_op_i == epp_pkg::OP_PROG_KEY) && (cmd_addr_i > epp_pkg::KEY_ADDR_MAX);
  wire logic take = ready_q && cmd_valid_i;
  wire logic take_ok = take && !bad_op && !bad_key;
  wire logic [4:0] pulse_total = (op_q == epp_pkg::OP_PROG_CODE) ? epp_pkg::PULSES_CODE
    : epp_pkg::PULSES_OTHER;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    timer_d = timer_done ? timer_q : timer_q - 14'h0001;
    pulses_d = pulses_q;
    case (state_q)
      EPP_IDLE: begin
        if (take_ok) begin
          state_d = EPP_SETUP;
          timer_d = SETUP_N;
          pulses_d = 5'h00;
        end
      end
      EPP_SETUP: begin
        if (timer_done) begin
          if (op_q == epp_pkg::OP_VERIFY || op_q == epp_pkg::OP_SIGNATURE) begin
            state_d = EPP_READ;
          end else begin
            state_d = EPP_VPP_ON;
            timer_d = VPP_N;
          end
        end
      end
      EPP_VPP_ON: begin
        if (timer_done) begin
          state_d = EPP_PULSE;
          timer_d = PULSE_N;
        end
      end
      EPP_PULSE: begin
        if (timer_done) begin
          state_d = EPP_GAP;
          timer_d = GAP_N;
          pulses_d = pulses_q + 5'h01;
        end
      end
      EPP_GAP: begin
        if (timer_done) begin
          if (pulses_q == pulse_total) begin
            state_d = EPP_VPP_OFF;
            timer_d = VPP_N;
          end else begin
            state_d = EPP_PULSE;
            timer_d = PULSE_N;
          end
        end
      end
      EPP_VPP_OFF: begin
        if (timer_done) begin
          state_d = EPP_IDLE;
        end
      end
      EPP_READ: state_d = EPP_IDLE;
      default: state_d = EPP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      osc_cnt_q <= 4'h0;
      osc_q <= 1'b0;
    end else if (clk_en_i) begin
      osc_cnt_q <= (osc_cnt_q == OSC_N) ? 4'h0 : osc_cnt_q + 4'h1;
      if (osc_cnt_q == OSC_N) begin
        osc_q <= !osc_q;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else if (clk_en_i) begin
      sync1_q <= data_port_lines_i;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_q <= EPP_IDLE;
      timer_q <= 14'h0000;
      pulses_q <= 5'h00;
    end else if (clk_en_i) begin
      state_q <= state_d;
      timer_q <= timer_d;
      pulses_q <= pulses_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      op_q <= epp_pkg::OP_VERIFY;
      addr_q <= 15'h0000;
      wdata_q <= 8'h00;
      mode_q <= epp_pkg::MODE_VERIFY;
      oe_q <= 1'b0;
    end else if (clk_en_i && take_ok) begin
      op_q <= cmd_op_i;
      addr_q <= cmd_addr_i;
      wdata_q <= cmd_data_i;
      mode_q <= mode_of(cmd_op_i);
      oe_q <= !is_read;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      vpp_q <= 1'b0;
      strobe_n_q <= 1'b1;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (clk_en_i) begin
      vpp_q <= (state_d == EPP_VPP_ON) || (state_d == EPP_PULSE) || (state_d == EPP_GAP);
      strobe_n_q <= (state_d != EPP_PULSE);
      ready_q <= (state_d == EPP_IDLE);
      done_q <= (state_q == EPP_READ) || (state_q == EPP_VPP_OFF && timer_done) ||
        (take && !take_ok);
      err_q <= take ? !take_ok : (done_q ? 1'b0 : err_q);
      if (state_q == EPP_READ) begin
        rdata_q <= sync2_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign cmd_ready_o = ready_q;
  assign done_o = done_q;
  assign error_o = err_q;
  assign rd_data_o = rdata_q;
  assign osc_o = osc_q;
  assign reset_pin_o = 1'b1;
  assign program_store_enable_o = 1'b0;
  assign latch_strobe_program_pulse_o = strobe_n_q;
  assign external_access_program_voltage_o = vpp_q;
  assign mode_pin_a_o = mode_q[4];
  assign enable_pin_o = mode_q[3];
  assign mode_pin_b_o = mode_q[2];
  assign mode_pin_c_o = mode_q[1];
  assign mode_pin_d_o = mode_q[0];
  assign low_address_lines_o = addr_q[7:0];
  assign mid_address_lines_o = addr_q[13:8];
  assign top_address_line_o = addr_q[14];
  assign data_port_lines_o = wdata_q;
  assign data_port_lines_oe_o = oe_q;
endmodule

/* File: epp_host_asserts.sv */
// Pin sequencing checks for the programmer controller.
`timescale 1ns/1ns
module epp_host_asserts (
  // Watched ports.
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_op_i,
  input wire logic [14:0] cmd_addr_i,
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire logic error_o,
  input wire logic reset_pin_o,
  input wire logic program_store_enable_o,
  input wire logic latch_strobe_program_pulse_o,
  input wire logic external_access_program_voltage_o,
  input wire logic data_port_lines_oe_o,
  input wire logic [7:0] low_address_lines_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [18:0] low_q;
  logic [18:0] vpp_q;
  wire logic stb;
  wire logic vpp;
  wire logic take;
  assign stb = latch_strobe_program_pulse_o;
  assign vpp = external_access_program_voltage_o;
  assign take = cmd_valid_i && cmd_ready_o;
  always_ff @(posedge sys_clk_i) begin
    low_q <= (stb || !reset_n_i) ? 19'h0 : low_q + 19'h1;
    vpp_q <= (!vpp || !reset_n_i) ? 19'h0 : vpp_q + 19'h1;
  end
  sequence s_bad;
    take && (cmd_op_i == 3'h7 || (cmd_op_i == epp_pkg::OP_PROG_KEY && cmd_addr_i > 15'h3f));
  endsequence
  a_fixed_pins: assert property (reset_pin_o && !program_store_enable_o)
    else $error("fixed control pin off its level");
  a_strobe_vpp: assert property (!stb |-> vpp)
    else $error("strobe low without program voltage");
  a_vpp_setup: assert property ($fell(stb) |-> vpp_q >= 19'h003e8)
    else $error("program voltage setup too short");
  a_pulse_width: assert property ($rose(stb) |-> low_q >= 19'h02328 && low_q <= 19'h02af8)
    else $error("strobe pulse width out of range");
  a_data_driven: assert property (!stb |-> data_port_lines_oe_o)
    else $error("data lines not driven during pulse");
  a_addr_held: assert property (!stb |=> stb || $stable(low_address_lines_o))
    else $error("address moved during pulse");
  a_done_pulse: assert property (done_o |=> !done_o ##[0:1] cmd_ready_o)
    else $error("done not a single pulse");
  a_refused_cmd: assert property (s_bad |-> ##[1:2] (done_o && error_o))
    else $error("bad command not refused");
  a_prog_start: assert property (take && cmd_op_i == 3'h0 |=> (!cmd_ready_o && !vpp)[*8])
    else $error("voltage raised before setup");
endmodule
bind epp_host epp_host_asserts u_chk (
  .sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i),
  .cmd_valid_i(cmd_valid_i),
  .cmd_op_i(cmd_op_i),
  .cmd_addr_i(cmd_addr_i),
  .cmd_ready_o(cmd_ready_o),
  .done_o(done_o),
  .error_o(error_o),
  .reset_pin_o(reset_pin_o),
  .program_store_enable_o(program_store_enable_o),
  .latch_strobe_program_pulse_o(latch_strobe_program_pulse_o),
  .external_access_program_voltage_o(external_access_program_voltage_o),
  .data_port_lines_oe_o(data_port_lines_oe_o),
  .low_address_lines_o(low_address_lines_o)
);

/* File: epp_dev_model.sv */
// Behavioural model of the device's programming and verify pins.
`timescale 1ns/1ns
module epp_dev_model #(
  parameter logic [7:0] SIG_BYTE = 8'h5a, // Arbitrary signature value.
  // Set for the mask ROM variant, whose array only acts once its lock is set.
  parameter bit MASK_ROM = 1'b0
) (
  // Pins from the controller.
  input wire logic osc_i,
  input wire logic stb_n_i,
  input wire logic vpp_i,
  input wire logic [4:0] mode_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] data_i,
  // Data lines back and pulse count.
  output logic [7:0] data_o,
  output int pulses_o
);
  logic [7:0] code [int];
  logic [7:0] key [64];
  logic [2:0] lock_q;
  logic [7:0] cv;
  logic [7:0] rv;
  logic [7:0] rk;
  initial begin
    foreach (key[i]) key[i] = 8'hff;
    lock_q = 3'h0;
    pulses_o = 0;
  end
  always @(negedge stb_n_i) begin
    if (vpp_i) begin
      pulses_o = pulses_o + 1;
      cv = code.exists(addr_i) ? code[addr_i] : 8'hff;
      case (mode_i)
        5'h0f: if (!lock_q[0]) code[addr_i] = cv & data_i;
        5'h0d: if (!lock_q[0] && addr_i < 15'h40) key[addr_i[5:0]] &= data_i;
        5'h1f: lock_q[0] = 1'b1;
        5'h1c: lock_q[1] = 1'b1;
        5'h16: lock_q[2] = 1'b1;
        default: ;
      endcase
    end
  end
  // Released lines toggle with the oscillator so a stale sample shows.
  always @* begin
    rv = code.exists(addr_i) ? code[addr_i] : 8'hff;
    rk = (MASK_ROM && !lock_q[0]) ? 8'hff : key[addr_i[5:0]];
    data_o = {8{osc_i}} ^ 8'h3c;
    if (stb_n_i && !vpp_i && mode_i == 5'h00) data_o = SIG_BYTE;
    if (stb_n_i && !vpp_i && mode_i == 5'h03 && !lock_q[1]) begin
      data_o = ~(rv ^ rk);
    end
  end
endmodule

/* File: epp_host_tb_top.sv */
// Self-checking bench for the programmer controller.
`timescale 1ns/1ns
module epp_host_tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [2:0] cmd_op_i = 3'h0;
  logic [14:0] cmd_addr_i = 15'h0;
  logic [7:0] cmd_data_i = 8'h0;
  wire logic rdy, done, err, osc, rp, pse, stb, vpp, oe, top;
  wire logic [4:0] mode;
  wire logic [7:0] rd, lo, dout, dev_d, bus;
  wire logic [5:0] mid;
  logic [7:0] d;
  logic osc_prev;
  logic [14:0] a;
  int pulses, p, n;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 32'h3af68162;
  logic [7:0] mem [int];
  logic [4:0] md [7] = '{5'h0f, 5'h0d, 5'h1f, 5'h1c, 5'h16, 5'h03, 5'h00};
  always #5 sys_clk_i = ~sys_clk_i;
  assign bus = oe ? dout : dev_d;
  epp_host dut (.sys_clk_i, .reset_n_i, .clk_en_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i,
    .cmd_data_i, .cmd_ready_o(rdy), .done_o(done), .error_o(err), .rd_data_o(rd), .osc_o(osc),
    .reset_pin_o(rp), .program_store_enable_o(pse), .latch_strobe_program_pulse_o(stb),
    .external_access_program_voltage_o(vpp), .mode_pin_a_o(mode[4]), .enable_pin_o(mode[3]),
    .mode_pin_b_o(mode[2]), .mode_pin_c_o(mode[1]), .mode_pin_d_o(mode[0]),
    .low_address_lines_o(lo), .mid_address_lines_o(mid), .top_address_line_o(top),
    .data_port_lines_i(bus), .data_port_lines_o(dout), .data_port_lines_oe_o(oe));
  epp_dev_model dev (.osc_i(osc), .stb_n_i(stb), .vpp_i(vpp), .mode_i(mode),
    .addr_i({top, mid, lo}), .data_i(bus), .data_o(dev_d), .pulses_o(pulses));
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wt(input int lim, input bit rd_y);
    n = 0;
    while ((rd_y ? rdy : done) !== 1'b1 && n < lim) begin
      @(posedge sys_clk_i);
      n++;
    end
    if ((rd_y ? rdy : done) !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic issue(input logic [2:0] op, input logic [14:0] ad, input logic [7:0] dd);
    wt(100, 1'b1);
    cmd_op_i <= op;
    cmd_addr_i <= ad;
    cmd_data_i <= dd;
    cmd_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] op, input logic [14:0] ad, input logic [7:0] dd);
    issue(op, ad, dd);
    wt(70000, 1'b0);
  endtask
  task automatic verify(input logic [14:0] ad);
    cmd(epp_pkg::OP_VERIFY, ad, 8'h0);
    d = mem.exists(ad) ? mem[ad] : 8'hff;
    chk({8'h0, rd}, {8'h0, ~(d ^ 8'hff)});
    chk({10'h0, oe, mode}, {10'h0, 1'b0, md[5]});
  endtask
  task automatic count_osc(input int cyc);
    p = 0;
    osc_prev = osc;
    repeat (cyc) begin
      @(posedge sys_clk_i);
      p = p + ((osc !== osc_prev) ? 1 : 0);
      osc_prev = osc;
    end
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    a = 15'($random(seed));
    d = 8'({$random(seed)} % 255);
    verify(a);
    p = pulses;
    cmd(epp_pkg::OP_PROG_CODE, a, d);
    mem[a] = d;
    chk(16'(pulses - p), 16'h0005);
    chk({1'b0, top, mid, lo}, {1'b0, a});
    chk({10'h0, oe, mode}, {10'h0, 1'b1, md[0]});
    verify(a);
    verify(a ^ 15'h4001);
    cmd(3'h7, a, 8'h0);
    chk({15'h0, err}, 16'h1);
    cmd(epp_pkg::OP_PROG_KEY, 15'h40, 8'h0);
    chk({15'h0, err}, 16'h1);
    chk({11'h0, mode}, {11'h0, md[5]});
    cmd(epp_pkg::OP_SIGNATURE, 15'h30, 8'h0);
    chk({3'h0, rd, mode}, {3'h0, 8'h5a, md[6]});
    count_osc(200);
    chk(16'(p), 16'h0014);
    clk_en_i <= 1'b0;
    @(posedge sys_clk_i);
    count_osc(30);
    clk_en_i <= 1'b1;
    chk(16'(p), 16'h0000);
    chk({14'h0, rp, pse}, 16'h0002);
    for (int k = 1; k < 5; k++) begin
      issue(3'(k), 15'h3f, 8'(k));
      repeat (20) @(posedge sys_clk_i);
      chk({9'h0, stb, vpp, mode}, {9'h0, 2'b10, md[k]});
      reset_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
    end
    verify(a);
    print_verdict();
  end
endmodule
